// ### hdl/pwm_limit_pkg.sv
// Package with register map, field layout and limit codes of the limiter
package pwm_limit_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] CFG_ADDR    = 8'h2e; // Modulation limit config
  localparam logic [7:0] STATUS_ADDR = 8'h40; // Limiter status, read only
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [7:0] ZERO_BYTE   = 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // Field positions of the config register
  localparam int FULL_BRIDGE_BIT = 7;
  localparam int HIGH_MSB        = 6;
  localparam int HIGH_LSB        = 4;
  localparam int RESERVED_BIT    = 3;
  localparam int SKIP_EN_BIT     = 2;
  localparam int LOW_MSB         = 1;
  localparam int LOW_LSB         = 0;

  // Writable bits; the reserved bit is masked off
  localparam logic [7:0] CFG_WMASK = 8'hf7;

  //////////////////////////////////////////////////////////////////////////
  // Status register bit positions
  localparam int ST_SKIP_BIT  = 0;
  localparam int ST_HIGH_BIT  = 1;
  localparam int ST_LOW_BIT   = 2;
  localparam int ST_FB_BIT    = 3;

  //////////////////////////////////////////////////////////////////////////
  // Duty is in 1/256 of the switching period; nominal is half a period
  localparam int          DUTY_W  = 9;
  localparam logic [8:0]  NOMINAL = 9'h080;
  localparam logic [8:0]  NO_DUTY = 9'h000;

  typedef logic [8:0] duty_t;
  typedef logic [7:0] offset_t;

  // Upper offsets, normal column: 12.5 .. 50 % of period
  localparam logic [7:0] HI_0 = 8'h20; // 12.5 %
  localparam logic [7:0] HI_1 = 8'h40; // 25 %
  localparam logic [7:0] HI_2 = 8'h50; // 31.25 %
  localparam logic [7:0] HI_3 = 8'h60; // 37.5 %
  localparam logic [7:0] HI_4 = 8'h70; // 43.75 %
  localparam logic [7:0] HI_5 = 8'h78; // 46.88 %
  localparam logic [7:0] HI_6 = 8'h7c; // 48.44 %
  localparam logic [7:0] HI_7 = 8'h80; // 50 %

  // Lower offsets, normal column: 50 .. 43.75 % of period
  localparam logic [7:0] LO_0 = 8'h80; // 50 %
  localparam logic [7:0] LO_1 = 8'h7c; // 48.44 %
  localparam logic [7:0] LO_2 = 8'h78; // 46.88 %
  localparam logic [7:0] LO_3 = 8'h70; // 43.75 %

endpackage : pwm_limit_pkg

// ### hdl/pwm_limit_decode.sv
// Decoder from limit codes to absolute duty limits
`timescale 1ns/1ps

module pwm_limit_decode (
  // Limit codes
  input  wire logic [2:0]                 high_code,
  input  wire logic [1:0]                 low_code,
  input  wire logic                       full_bridge,
  // Absolute duty limits
  output      pwm_limit_pkg::duty_t       high_duty,
  output      pwm_limit_pkg::duty_t       low_duty
);

  pwm_limit_pkg::offset_t hi_off;
  pwm_limit_pkg::offset_t lo_off;
  pwm_limit_pkg::offset_t hi_sel;
  pwm_limit_pkg::offset_t lo_sel;

  // Normal column of offsets from nominal
  always_comb begin
    case (high_code)
      3'h0:    hi_off = pwm_limit_pkg::HI_0;
      3'h1:    hi_off = pwm_limit_pkg::HI_1;
      3'h2:    hi_off = pwm_limit_pkg::HI_2;
      3'h3:    hi_off = pwm_limit_pkg::HI_3;
      3'h4:    hi_off = pwm_limit_pkg::HI_4;
      3'h5:    hi_off = pwm_limit_pkg::HI_5;
      3'h6:    hi_off = pwm_limit_pkg::HI_6;
      default: hi_off = pwm_limit_pkg::HI_7;
    endcase
    case (low_code)
      2'h0:    lo_off = pwm_limit_pkg::LO_0;
      2'h1:    lo_off = pwm_limit_pkg::LO_1;
      2'h2:    lo_off = pwm_limit_pkg::LO_2;
      default: lo_off = pwm_limit_pkg::LO_3;
    endcase
  end

  // Full-bridge column is exactly half; all table entries are even
  always_comb begin
    hi_sel = full_bridge ? {1'b0, hi_off[7:1]} : hi_off;
    lo_sel = full_bridge ? {1'b0, lo_off[7:1]} : lo_off;
  end

  // Offsets never pass nominal, so neither sum wraps
  assign high_duty = pwm_limit_pkg::NOMINAL + {1'b0, hi_sel};
  assign low_duty  = pwm_limit_pkg::NOMINAL - {1'b0, lo_sel};

endmodule : pwm_limit_decode

// ### hdl/pwm_mod_limiter.sv
// Modulation limiter between the loop filter and the PWM edge generator
`timescale 1ns/1ps

module pwm_mod_limiter (
  // Clock and reset
  input  wire logic                 REF_CLK,
  input  wire logic                 RESET,
  // Register port
  input  wire logic [7:0]           REG_ADDR,
  input  wire logic [7:0]           REG_WDATA,
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  output      logic [7:0]           REG_RDATA,
  // Duty demand from the loop filter
  input  wire pwm_limit_pkg::duty_t DEMAND,
  input  wire logic                 DEMAND_VALID,
  // Limited duty to the PWM edge generator
  output      pwm_limit_pkg::duty_t DUTY_A,
  output      pwm_limit_pkg::duty_t DUTY_B,
  output      logic                 DUTY_VALID,
  output      logic                 PULSE_SKIP,
  output      logic                 CLAMP_HIGH,
  output      logic                 CLAMP_LOW
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Configuration and its fields
  logic [7:0]           cfg_q;
  logic [7:0]           cfg_d;
  logic                 cfg_write;
  logic                 full_bridge;
  logic                 skip_en;
  logic [2:0]           high_code;
  logic [1:0]           low_code;

  // Absolute limits and the decision against them
  pwm_limit_pkg::duty_t high_duty;
  pwm_limit_pkg::duty_t low_duty;
  pwm_limit_pkg::duty_t limited;
  logic                 over_high;
  logic                 under_low;
  logic                 skip_now;

  // Legs that carry the result
  logic [1:0]           leg_on;
  pwm_limit_pkg::duty_t leg_q [2];

  // Outcome flags of the last demand
  logic                 skip_q;
  logic                 skip_d;
  logic                 clamp_hi_q;
  logic                 clamp_hi_d;
  logic                 clamp_lo_q;
  logic                 clamp_lo_d;
  logic                 fb_used_q;
  logic                 fb_used_d;
  logic                 valid_q;

  // Register read
  logic [7:0]           rdata_q;
  logic [7:0]           rdata_d;
  logic [7:0]           status_word;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register

  // Write decode; writes to any other address are ignored
  always_comb begin
    cfg_write = REG_WR && (REG_ADDR == pwm_limit_pkg::CFG_ADDR);
  end

  // Reserved bit is masked on write so it always reads back as zero
  always_comb begin
    cfg_d = cfg_q;
    if (cfg_write) begin
      cfg_d = REG_WDATA & pwm_limit_pkg::CFG_WMASK;
    end
  end

  // Config register holds its reset value until software writes it
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      cfg_q <= pwm_limit_pkg::CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Full-bridge bit picks the halved column and the second leg
  always_comb begin
    full_bridge = cfg_q[pwm_limit_pkg::FULL_BRIDGE_BIT];
  end

  // Pulse-skip enable
  always_comb begin
    skip_en = cfg_q[pwm_limit_pkg::SKIP_EN_BIT];
  end

  // Upper limit code
  always_comb begin
    high_code = cfg_q[pwm_limit_pkg::HIGH_MSB:pwm_limit_pkg::HIGH_LSB];
  end

  // Lower limit code
  always_comb begin
    low_code = cfg_q[pwm_limit_pkg::LOW_MSB:pwm_limit_pkg::LOW_LSB];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limit decode

  // Limits follow the register at once; a new code applies to the next
  // demand and never cuts a result already handed out
  pwm_limit_decode u_decode (
    .high_code   (high_code),
    .low_code    (low_code),
    .full_bridge (full_bridge),
    .high_duty   (high_duty),
    .low_duty    (low_duty)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clamp and skip decision

  // Demand above the upper limit is capped
  always_comb begin
    over_high = DEMAND > high_duty;
  end

  // Demand below the lower limit is clamped or skipped; equal passes
  always_comb begin
    under_low = DEMAND < low_duty;
  end

  // Skipping wins over clamping; a narrow pulse would be worse than none
  always_comb begin
    skip_now = skip_en && under_low;
  end

  // Limited duty; the two limits never cross, so at most one applies
  always_comb begin
    if (over_high) begin
      limited = high_duty;
    end else if (under_low) begin
      limited = low_duty;
    end else begin
      limited = DEMAND;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output steering

  // Leg A always carries the result; leg B only in full bridge, where both
  // legs get the same width so the volt-seconds are shared evenly
  always_comb begin
    leg_on[0] = 1'b1;
    leg_on[1] = full_bridge;
  end

  // One copy per leg; a skipped pulse clears both legs alike
  for (genvar leg = 0; leg < 2; leg++) begin : g_leg
    pwm_limit_pkg::duty_t leg_d;

    // Next duty of this leg, held between demands
    always_comb begin
      leg_d = leg_q[leg];
      if (DEMAND_VALID) begin
        if (skip_now || !leg_on[leg]) begin
          leg_d = pwm_limit_pkg::NO_DUTY;
        end else begin
          leg_d = limited;
        end
      end
    end

    // Leg duty register, cleared by reset
    always_ff @(posedge REF_CLK) begin
      if (RESET) begin
        leg_q[leg] <= pwm_limit_pkg::NO_DUTY;
      end else begin
        leg_q[leg] <= leg_d;
      end
    end
  end

  // Outcome flags change only when a demand is taken
  always_comb begin
    skip_d     = skip_q;
    clamp_hi_d = clamp_hi_q;
    clamp_lo_d = clamp_lo_q;
    fb_used_d  = fb_used_q;
    if (DEMAND_VALID) begin
      skip_d     = skip_now;
      clamp_hi_d = over_high;
      clamp_lo_d = under_low && !skip_now;
      fb_used_d  = full_bridge;
    end
  end

  // Skip flag: the last demand left both legs idle
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      skip_q <= 1'b0;
    end else begin
      skip_q <= skip_d;
    end
  end

  // Upper clamp flag
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      clamp_hi_q <= 1'b0;
    end else begin
      clamp_hi_q <= clamp_hi_d;
    end
  end

  // Lower clamp flag; never set together with the skip flag
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      clamp_lo_q <= 1'b0;
    end else begin
      clamp_lo_q <= clamp_lo_d;
    end
  end

  // Column in use when the last demand was taken
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      fb_used_q <= 1'b0;
    end else begin
      fb_used_q <= fb_used_d;
    end
  end

  // Valid strobe marks the cycle after each demand
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= DEMAND_VALID;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read

  // Status word packs the flags of the last result
  always_comb begin
    status_word = pwm_limit_pkg::ZERO_BYTE;
    status_word[pwm_limit_pkg::ST_SKIP_BIT] = skip_q;
    status_word[pwm_limit_pkg::ST_HIGH_BIT] = clamp_hi_q;
    status_word[pwm_limit_pkg::ST_LOW_BIT]  = clamp_lo_q;
    status_word[pwm_limit_pkg::ST_FB_BIT]   = fb_used_q;
  end

  // Read data stand for one cycle only; unmapped reads give zero
  always_comb begin
    rdata_d = pwm_limit_pkg::ZERO_BYTE;
    if (REG_RD) begin
      case (REG_ADDR)
        pwm_limit_pkg::CFG_ADDR:    rdata_d = cfg_q;
        pwm_limit_pkg::STATUS_ADDR: rdata_d = status_word;
        default:                    rdata_d = pwm_limit_pkg::ZERO_BYTE;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rdata_q <= pwm_limit_pkg::ZERO_BYTE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops

  // Read data
  assign REG_RDATA  = rdata_q;

  // Leg duties from the per-leg registers
  assign DUTY_A     = leg_q[0];
  assign DUTY_B     = leg_q[1];

  // Strobe and outcome flags
  assign DUTY_VALID = valid_q;
  assign PULSE_SKIP = skip_q;
  assign CLAMP_HIGH = clamp_hi_q;
  assign CLAMP_LOW  = clamp_lo_q;

endmodule : pwm_mod_limiter

// ### verif/pwm_stage_model.sv
// Power stage model that applies each limited duty to two switch legs
`timescale 1ns/1ps

module pwm_stage_model (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Limited duty from the limiter
  input  wire pwm_limit_pkg::duty_t duty_a,
  input  wire pwm_limit_pkg::duty_t duty_b,
  input  wire logic                 duty_valid,
  // Duty now applied to each leg
  output      pwm_limit_pkg::duty_t leg_a_q,
  output      pwm_limit_pkg::duty_t leg_b_q
);
  // Legs change only on a fresh duty; a stage never guesses between updates
  always_ff @(posedge clk) begin
    if (rst) begin
      leg_a_q <= 9'h000;
      leg_b_q <= 9'h000;
    end else if (duty_valid) begin
      leg_a_q <= duty_a;
      leg_b_q <= duty_b;
    end
  end
endmodule : pwm_stage_model

// ### verif/pwm_mod_limiter_checker.sv
// Checker of the limiter's demand path and register read port
`timescale 1ns/1ps

module pwm_mod_limiter_checker (
  // Clock, reset and register read
  input wire logic                 REF_CLK,
  input wire logic                 RESET,
  input wire logic                 REG_RD,
  input wire logic [7:0]           REG_RDATA,
  // Demand path
  input wire pwm_limit_pkg::duty_t DEMAND,
  input wire logic                 DEMAND_VALID,
  input wire pwm_limit_pkg::duty_t DUTY_A,
  input wire pwm_limit_pkg::duty_t DUTY_B,
  input wire logic                 DUTY_VALID,
  input wire logic                 PULSE_SKIP,
  input wire logic                 CLAMP_HIGH,
  input wire logic                 CLAMP_LOW
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  ////////////////////////////////////////
  // A taken demand, then each kind of outcome one cycle on
  sequence took_high; DEMAND_VALID ##1 CLAMP_HIGH; endsequence
  sequence took_low; DEMAND_VALID ##1 CLAMP_LOW; endsequence
  sequence took_skip; DEMAND_VALID ##1 PULSE_SKIP; endsequence
  sequence took_free;
    DEMAND_VALID ##1 !(CLAMP_HIGH || CLAMP_LOW || PULSE_SKIP);
  endsequence
  ////////////////////////////////////////
  answer_pulse_a:
    assert property (DEMAND_VALID |=> DUTY_VALID) else $error("no answer");
  duty_hold_a:
    assert property (!DEMAND_VALID |=> !DUTY_VALID && $stable(DUTY_A))
    else $error("duty moved without demand");
  high_cap_a:
    assert property (took_high |-> DUTY_A < $past(DEMAND))
    else $error("high clamp not below demand");
  high_range_a:
    assert property (DUTY_VALID |-> DUTY_A <= 9'h100)
    else $error("duty above full period");
  low_clamp_a:
    assert property (took_low |-> DUTY_A > $past(DEMAND))
    else $error("low clamp not above demand");
  pass_free_a:
    assert property (took_free |-> DUTY_A == $past(DEMAND))
    else $error("unclamped demand altered");
  skip_zero_a:
    assert property (took_skip |-> DUTY_A == 9'h000 && DUTY_B == 9'h000
      && $past(DEMAND) < 9'h048) else $error("bad skip");
  one_flag_a:
    assert property (DUTY_VALID |-> $onehot0({PULSE_SKIP, CLAMP_HIGH,
      CLAMP_LOW})) else $error("several outcome flags");
  bridge_leg_a:
    assert property (DUTY_B != 9'h000 |-> DUTY_B == DUTY_A)
    else $error("legs differ");
  rdata_idle_a:
    assert property (!REG_RD |=> REG_RDATA == 8'h00)
    else $error("read data without read");
endmodule : pwm_mod_limiter_checker

bind pwm_mod_limiter pwm_mod_limiter_checker u_pwm_mod_limiter_checker (
  .REF_CLK(REF_CLK), .RESET(RESET), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .DEMAND(DEMAND), .DEMAND_VALID(DEMAND_VALID),
  .DUTY_A(DUTY_A), .DUTY_B(DUTY_B), .DUTY_VALID(DUTY_VALID),
  .PULSE_SKIP(PULSE_SKIP), .CLAMP_HIGH(CLAMP_HIGH), .CLAMP_LOW(CLAMP_LOW));

// ### verif/pwm_mod_limiter_bench.sv
// Self-checking bench of the modulation limiter
`timescale 1ns/1ps
`define CHK(got, exp, what) begin tests_run++; if ((got) !== (exp)) begin \
  errors++; $display("mismatch %s exp %h got %h", what, exp, got); end end

module pwm_mod_limiter_bench;
  logic                 ref_clk = 1'b0;
  logic                 reset = 1'b1;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic                 dem_valid = 1'b0;
  logic [7:0]           reg_addr = 8'h00;
  logic [7:0]           reg_wdata = 8'h00;
  pwm_limit_pkg::duty_t demand = 9'h000;
  logic [7:0]           reg_rdata;
  pwm_limit_pkg::duty_t duty_a, duty_b, leg_a, leg_b;
  logic                 duty_valid, skip, clamp_hi, clamp_lo;
  int                   errors = 0;
  int                   tests_run = 0;
  int                   hi_off [8] = '{32, 64, 80, 96, 112, 120, 124, 128};
  int                   lo_off [4] = '{128, 124, 120, 112};

  pwm_mod_limiter u_pwm_mod_limiter (.REF_CLK(ref_clk), .RESET(reset),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .DEMAND(demand),
    .DEMAND_VALID(dem_valid), .DUTY_A(duty_a), .DUTY_B(duty_b),
    .DUTY_VALID(duty_valid), .PULSE_SKIP(skip), .CLAMP_HIGH(clamp_hi),
    .CLAMP_LOW(clamp_lo));
  pwm_stage_model u_pwm_stage_model (.clk(ref_clk), .rst(reset),
    .duty_a(duty_a), .duty_b(duty_b), .duty_valid(duty_valid),
    .leg_a_q(leg_a), .leg_b_q(leg_b));

  // 50 MHz clock
  initial forever #10 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  // Register writes and reads, one strobe cycle each
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 `CHK(reg_rdata, e, "read data")
  endtask : rd

  // One demand; expectation built from the limit tables and config
  task automatic dem(input pwm_limit_pkg::duty_t d, input logic [7:0] c);
    pwm_limit_pkg::duty_t hi, lo, ea, eb;
    hi = 9'(128 + (hi_off[c[6:4]] >> c[7]));
    lo = 9'(128 - (lo_off[c[1:0]] >> c[7]));
    ea = d > hi ? hi : d < lo ? (c[2] ? 9'h000 : lo) : d;
    eb = c[7] ? ea : 9'h000;
    @(posedge ref_clk);
    demand    <= d;
    dem_valid <= 1'b1;
    @(posedge ref_clk);
    dem_valid <= 1'b0;
    #1 `CHK(duty_a, ea, "leg a duty")
    `CHK(duty_b, eb, "leg b duty")
    `CHK({skip, clamp_hi, clamp_lo}, {d < lo && c[2], d > hi,
      d < lo && !c[2]}, "flags")
    @(posedge ref_clk);
    #1 `CHK(leg_b, eb, "stage leg b")
    `CHK(leg_a, ea, "stage leg a")
  endtask : dem

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    conclude();
  end
  ////////////////////////////////////////
  // Test sequence
  initial begin
    logic [7:0] cfg;
    int         lo;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rd(pwm_limit_pkg::CFG_ADDR, pwm_limit_pkg::CFG_RESET);
    rd(pwm_limit_pkg::STATUS_ADDR, 8'h00);
    rd(8'h00, 8'h00);
    wr(pwm_limit_pkg::CFG_ADDR, 8'hff);
    rd(pwm_limit_pkg::CFG_ADDR, 8'hf7);
    $display("test registers done");
    // Every upper code in both columns, lower codes cycling
    for (int i = 0; i < 16; i++) begin
      cfg = {i[3], i[2:0], 2'b00, i[1:0]};
      wr(pwm_limit_pkg::CFG_ADDR, cfg);
      dem(9'h1ff, cfg);
      dem(9'h000, cfg);
      dem(9'h07f, cfg);
    end
    $display("test limits done");
    // Skipping: the limit itself passes, one below is dropped
    for (int i = 0; i < 8; i++) begin
      cfg = {i[2], 3'h7, 2'b01, i[1:0]};
      wr(pwm_limit_pkg::CFG_ADDR, cfg);
      lo = 128 - (lo_off[i[1:0]] >> i[2]);
      dem(9'(lo), cfg);
      if (lo > 0) dem(9'(lo - 1), cfg);
    end
    rd(pwm_limit_pkg::STATUS_ADDR, 8'h09);
    $display("test skipping done");
    conclude();
  end
endmodule : pwm_mod_limiter_bench
